/* dv/aso_monitor.sv */
`timescale 1ns/10ps
module aso_monitor
	import aso_pkg::*;
(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [3:0] pstrb,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr
);
	// ==========
	// bus answer checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic unm;
	logic rdq;
	logic ptr_rd;
	logic file_rd;
	// decode of unmapped places and reads
	assign unm = paddr[11:9] != 3'h1 && paddr[11:2] > 10'h005;
	assign rdq = pready && !pwrite;
	assign ptr_rd = rdq && (paddr[11:2] == 10'h003 || paddr[11:2] == 10'h004);
	assign file_rd = rdq && paddr[11:9] == 3'h1;
	sequence first_access;
		psel && penable && !pready;
	endsequence
	sequence one_answer;
		pready ##1 !pready;
	endsequence
	AST_ANSWER: assert property (first_access |=> one_answer)
		else $error("no answer");
	AST_IDLE: assert property (!(psel && penable) |-> !pready)
		else $error("stray ready");
	AST_ONE: assert property ($rose(pready) |=> $fell(pready))
		else $error("long ready");
	AST_ZERO: assert property (!pready |-> !pslverr && prdata == '0)
		else $error("data off ready");
	AST_UNMAP: assert property (pready && unm |-> pslverr)
		else $error("no error");
	AST_MAPPED: assert property (pready && !unm |-> !pslverr)
		else $error("false error");
	AST_PTRRD: assert property (ptr_rd |-> prdata[31:16] == 16'h0)
		else $error("pointer width");
	AST_FILERD: assert property (file_rd |-> prdata[31:8] == 24'h0)
		else $error("file width");
endmodule
bind aso_top aso_monitor u_mon(.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);

/* dv/tb.sv */
`timescale 1ns/10ps
module tb;
	import aso_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, erv;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic [3:0] pstrb = 4'hf;
	int num_errors = 0, check_count = 0;
	// ==========
	// clock, design and helpers
	always #4 pclk = ~pclk;
	aso_top u_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr);
	task finish_test;
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) num_errors++;
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rdv);
	endtask
	// command word: op, dest, pointer, file index, literal
	task cmd(input logic [3:0] o, input logic d, input logic p,
		input logic [6:0] a, input logic [7:0] k);
		wr(OFS_CMD, {8'h00, k, 1'b0, a, 2'b00, p, d, o});
	endtask
	function logic [11:0] fa(input logic [6:0] i);
		return {3'h1, i, 2'b00};
	endfunction
	// ==========
	// scenarios
	task t_ptr;
		wr(OFS_STATUS, 32'h7);
		wr(OFS_PTR0, 32'hffe0);
		wr(OFS_PTR1, 32'h0010);
		cmd(4'h1, 1'b0, 1'b0, 7'h00, 8'h1f);
		rd("p0", OFS_PTR0, 32'hffff);
		cmd(4'h1, 1'b0, 1'b0, 7'h00, 8'h01);
		rd("p0", OFS_PTR0, 32'h0);
		cmd(4'h1, 1'b0, 1'b1, 7'h00, 8'h20);
		rd("p1", OFS_PTR1, 32'hfff0);
		rd("st", OFS_STATUS, 32'h7);
	endtask
	task t_lit;
		wr(OFS_STATUS, 32'h1);
		wr(OFS_ACC, 32'h0f);
		cmd(4'h2, 1'b0, 1'b0, 7'h00, 8'hf0);
		rd("a", OFS_ACC, 32'h0);
		rd("st", OFS_STATUS, 32'h5);
		wr(OFS_ACC, 32'h88);
		cmd(4'h3, 1'b1, 1'b0, 7'h00, 8'h88);
		rd("a", OFS_ACC, 32'h10);
		rd("st", OFS_STATUS, 32'h3);
	endtask
	task t_file;
		wr(OFS_ACC, 32'hc4);
		wr(fa(7'd5), 32'h3c);
		cmd(4'h5, 1'b0, 1'b0, 7'd5, 8'h00);
		rd("a", OFS_ACC, 32'h0);
		rd("st", OFS_STATUS, 32'h7);
		rd("f", fa(7'd5), 32'h3c);
		wr(OFS_ACC, 32'h0f);
		cmd(4'h4, 1'b1, 1'b0, 7'd5, 8'h00);
		rd("f", fa(7'd5), 32'h0c);
		rd("a", OFS_ACC, 32'h0f);
		rd("st", OFS_STATUS, 32'h3);
	endtask
	task t_asr;
		wr(OFS_STATUS, 32'h0);
		wr(fa(7'd127), 32'h81);
		cmd(4'h6, 1'b1, 1'b0, 7'd127, 8'h00);
		rd("f", fa(7'd127), 32'hc0);
		rd("st", OFS_STATUS, 32'h1);
		wr(fa(7'd126), 32'h01);
		cmd(4'h6, 1'b0, 1'b0, 7'd126, 8'h00);
		rd("a", OFS_ACC, 32'h0);
		rd("st", OFS_STATUS, 32'h5);
	endtask
	task t_awc;
		wr(OFS_STATUS, 32'h1);
		wr(OFS_ACC, 32'h07);
		wr(fa(7'd2), 32'h08);
		cmd(4'h7, 1'b1, 1'b0, 7'd2, 8'h00);
		rd("f", fa(7'd2), 32'h10);
		rd("st", OFS_STATUS, 32'h2);
		rd("l", OFS_LAST, 32'h10);
		wr(OFS_LAST, 32'h55);
		rd("l", OFS_LAST, 32'h10);
		rd("c", OFS_CMD, 32'h0);
		chk("e", 32'h0, {31'h0, erv});
		rd("u", 12'h018, 32'h0);
		chk("e", 32'h1, {31'h0, erv});
	endtask
	// no-op and undefined op codes leave acc and flags alone
	task t_nop;
		wr(OFS_ACC, 32'h5a);
		wr(OFS_STATUS, 32'h0);
		cmd(4'h0, 1'b0, 1'b0, 7'h00, 8'h01);
		cmd(4'h8, 1'b0, 1'b0, 7'h00, 8'h01);
		rd("a", OFS_ACC, 32'h5a);
		rd("st", OFS_STATUS, 32'h0);
	endtask
	// ==========
	// main sequence and watchdog
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("p1", OFS_PTR1, 32'h0);
		t_ptr;
		t_lit;
		t_file;
		t_asr;
		t_awc;
		t_nop;
		finish_test;
	end
	initial begin
		#100000;
		num_errors++;
		finish_test;
	end
endmodule

/* hw/aso_alu.sv */
`timescale 1ns/10ps
module aso_alu
	import aso_pkg::*;
(
	aso_alu_if.calc alu
);

	// ==========================================================
	// byte arithmetic and logic
	always_comb begin
		logic cin_eff;
		logic [8:0] sum;
		logic [4:0] low;
		cin_eff = 1'b0;
		sum = 9'h000;
		low = 5'h00;
		if (alu.op == OP_ADD_FILE_WITH_RIPPLE) begin
			cin_eff = alu.cin; // carry joins the sum
		end
		sum = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, cin_eff};
		low = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, cin_eff};
		alu.res = 8'h00;
		alu.c_out = 1'b0;
		alu.nr_out = 1'b0;
		case (alu.op)
			OP_AND_IMMEDIATE, OP_AND_FILE_REG: begin
				alu.res = alu.a & alu.b;
			end
			OP_ADD_IMMEDIATE, OP_ADD_FILE_REG,
			OP_ADD_FILE_WITH_RIPPLE: begin
				alu.res = sum[7:0];
				alu.c_out = sum[8]; // carry out of bit 7
				alu.nr_out = low[4]; // carry out of bit 3
			end
			OP_ARITH_SHIFT_RIGHT: begin
				alu.res = {alu.b[7], alu.b[7:1]};
				alu.c_out = alu.b[0];
			end
			default: begin
				alu.res = 8'h00;
			end
		endcase
		alu.z_out = (alu.res == 8'h00);
	end

endmodule

/* hw/aso_alu_if.sv */
`timescale 1ns/10ps
interface aso_alu_if;
	import aso_pkg::*;
	aso_op_t op;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic [7:0] res;
	logic c_out;
	logic nr_out;
	logic z_out;
	modport calc(input op, input a, input b, input cin,
		output res, output c_out, output nr_out, output z_out);
	modport user(output op, output a, output b, output cin,
		input res, input c_out, input nr_out, input z_out);
endinterface

/* hw/aso_pkg.sv */
package aso_pkg;

	// ==========================================================
	// register map (byte addresses on the bus)
	localparam logic [11:0] OFS_CMD = 12'h000;
	localparam logic [11:0] OFS_ACC = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_PTR0 = 12'h00c;
	localparam logic [11:0] OFS_PTR1 = 12'h010;
	localparam logic [11:0] OFS_LAST = 12'h014;
	localparam logic [2:0] FR_PAGE = 3'h1;
	localparam int FR_PAGE_LSB = 9;
	localparam int FR_IDX_LSB = 2;

	// ==========================================================
	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_DEST_BIT = 4;
	localparam int CMD_PTR_BIT = 5;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_LIT_LSB = 16;

	// ==========================================================
	// status word fields
	localparam int ST_C_BIT = 0;
	localparam int ST_NR_BIT = 1;
	localparam int ST_Z_BIT = 2;

	// ==========================================================
	// reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [7:0] FR_RST = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// ==========================================================
	// operations
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_POINTER_ADD_IMM = 4'h1,
		OP_AND_IMMEDIATE = 4'h2,
		OP_ADD_IMMEDIATE = 4'h3,
		OP_AND_FILE_REG = 4'h4,
		OP_ADD_FILE_REG = 4'h5,
		OP_ARITH_SHIFT_RIGHT = 4'h6,
		OP_ADD_FILE_WITH_RIPPLE = 4'h7
	} aso_op_t;

	typedef enum logic [2:0] {
		REG_NONE = 3'h0,
		REG_CMD = 3'h1,
		REG_ACC = 3'h2,
		REG_STATUS = 3'h3,
		REG_PTR0 = 3'h4,
		REG_PTR1 = 3'h5,
		REG_LAST = 3'h6,
		REG_FILE = 3'h7
	} aso_reg_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_ANSWER = 1'b1
	} aso_state_t;

endpackage

/* hw/aso_top.sv */
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module aso_top
	import aso_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ==========================================================
	// state
	typedef struct packed {
		aso_state_t st;
		logic [7:0] acc;
		logic c;
		logic nr;
		logic z;
		logic [1:0][15:0] ptr;
		logic [127:0][7:0] fr;
		logic [7:0] last;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} aso_regs_t;

	aso_regs_t s_reg;
	aso_regs_t s_next;

	aso_alu_if alu_bus();

	// ==========================================================
	// address decode, shared by read and write paths
	function automatic aso_reg_t aso_decode(input logic [11:0] a);
		aso_reg_t r;
		r = REG_NONE;
		if (a[11:FR_PAGE_LSB] == FR_PAGE) begin
			r = REG_FILE;
		end else begin
			case ({a[11:2], 2'b00})
				OFS_CMD: r = REG_CMD;
				OFS_ACC: r = REG_ACC;
				OFS_STATUS: r = REG_STATUS;
				OFS_PTR0: r = REG_PTR0;
				OFS_PTR1: r = REG_PTR1;
				OFS_LAST: r = REG_LAST;
				default: r = REG_NONE;
			endcase
		end
		return r;
	endfunction

	// which status flags an operation may change: {z, nr, c}
	function automatic logic [2:0] aso_flag_mask(input aso_op_t op);
		logic [2:0] m;
		m = 3'b000;
		case (op)
			OP_AND_IMMEDIATE, OP_AND_FILE_REG: m = 3'b100;
			OP_ADD_IMMEDIATE, OP_ADD_FILE_REG,
			OP_ADD_FILE_WITH_RIPPLE: m = 3'b111;
			OP_ARITH_SHIFT_RIGHT: m = 3'b101;
			default: m = 3'b000; // pointer add keeps flags
		endcase
		return m;
	endfunction

	// ==========================================================
	// command word fields
	aso_op_t cmd_op;
	logic cmd_dest;
	logic cmd_ptr;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_lit;
	logic [7:0] file_val;
	logic lit_op;

	assign cmd_op = aso_op_t'(pwdata[CMD_OP_LSB +: 4]);
	assign cmd_dest = pwdata[CMD_DEST_BIT];
	assign cmd_ptr = pwdata[CMD_PTR_BIT];
	assign cmd_addr = pwdata[CMD_ADDR_LSB +: 7];
	assign cmd_lit = pwdata[CMD_LIT_LSB +: 8];
	assign file_val = s_reg.fr[cmd_addr];
	assign lit_op = (cmd_op == OP_AND_IMMEDIATE) ||
		(cmd_op == OP_ADD_IMMEDIATE);

	// operands to the byte unit
	assign alu_bus.op = cmd_op;
	assign alu_bus.a = s_reg.acc;
	assign alu_bus.b = lit_op ? cmd_lit : file_val;
	assign alu_bus.cin = s_reg.c;

	aso_alu u_alu (
		.alu(alu_bus.calc)
	);

	// ==========================================================
	// next state
	always_comb begin
		aso_reg_t sel;
		logic commit;
		logic [2:0] fm;
		logic [15:0] ptr_sum;
		logic [15:0] lit_ext;
		logic [31:0] rd;
		logic ptr_i;
		sel = aso_decode(paddr);
		commit = psel && penable && s_reg.pready;
		fm = aso_flag_mask(cmd_op);
		lit_ext = {{10{cmd_lit[5]}}, cmd_lit[5:0]}; // sign extend
		ptr_i = cmd_ptr;
		ptr_sum = s_reg.ptr[ptr_i] + lit_ext; // drops bit 16
		rd = RDATA_RST;
		s_next = s_reg;

		// read data for the answer cycle
		case (sel)
			REG_CMD: rd = RDATA_RST;
			REG_ACC: rd = {24'h000000, s_reg.acc};
			REG_STATUS: rd = {29'h00000000, s_reg.z, s_reg.nr, s_reg.c};
			REG_PTR0: rd = {16'h0000, s_reg.ptr[0]};
			REG_PTR1: rd = {16'h0000, s_reg.ptr[1]};
			REG_LAST: rd = {24'h000000, s_reg.last};
			REG_FILE: rd = {24'h000000, s_reg.fr[paddr[8:FR_IDX_LSB]]};
			default: rd = RDATA_RST;
		endcase

		// bus handshake, one wait cycle in the access phase
		case (s_reg.st)
			ST_IDLE: begin
				s_next.pready = 1'b0;
				if (psel && penable) begin
					s_next.st = ST_ANSWER;
					s_next.pready = 1'b1;
					s_next.pslverr = (sel == REG_NONE);
					s_next.prdata = pwrite ? RDATA_RST : rd;
				end
			end
			ST_ANSWER: begin
				s_next.st = ST_IDLE;
				s_next.pready = 1'b0;
				s_next.pslverr = 1'b0;
				s_next.prdata = RDATA_RST;
			end
			default: begin
				s_next.st = ST_IDLE;
				s_next.pready = 1'b0;
			end
		endcase

		// write effects at the completing edge
		if (commit && pwrite) begin
			case (sel)
				REG_ACC: begin
					if (pstrb[0]) s_next.acc = pwdata[7:0];
				end
				REG_STATUS: begin
					if (pstrb[0]) begin
						s_next.c = pwdata[ST_C_BIT];
						s_next.nr = pwdata[ST_NR_BIT];
						s_next.z = pwdata[ST_Z_BIT];
					end
				end
				REG_PTR0, REG_PTR1: begin
					ptr_i = (sel == REG_PTR1);
					if (pstrb[0]) s_next.ptr[ptr_i][7:0] = pwdata[7:0];
					if (pstrb[1]) s_next.ptr[ptr_i][15:8] = pwdata[15:8];
				end
				REG_FILE: begin
					if (pstrb[0]) begin
						s_next.fr[paddr[8:FR_IDX_LSB]] = pwdata[7:0];
					end
				end
				REG_CMD: begin
					if (cmd_op == OP_POINTER_ADD_IMM) begin
						s_next.ptr[cmd_ptr] = ptr_sum;
					end else if (cmd_op != OP_NOP &&
						cmd_op <= OP_ADD_FILE_WITH_RIPPLE) begin
						s_next.last = alu_bus.res;
						if (lit_op || !cmd_dest) begin
							s_next.acc = alu_bus.res;
						end else begin
							s_next.fr[cmd_addr] = alu_bus.res;
						end
						if (fm[0]) s_next.c = alu_bus.c_out;
						if (fm[1]) s_next.nr = alu_bus.nr_out;
						if (fm[2]) s_next.z = alu_bus.z_out;
					end
				end
				default: begin
					s_next.last = s_reg.last;
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg.st <= ST_IDLE;
			s_reg.acc <= ACC_RST;
			s_reg.c <= 1'b0;
			s_reg.nr <= 1'b0;
			s_reg.z <= 1'b0;
			s_reg.ptr <= {2{PTR_RST}};
			s_reg.fr <= {128{FR_RST}};
			s_reg.last <= ACC_RST;
			s_reg.prdata <= RDATA_RST;
			s_reg.pready <= 1'b0;
			s_reg.pslverr <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// bus outputs straight from flip-flops
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;

endmodule
